/* File: mis_cpu_model.sv */
// Purpose: cpu core stand-in that takes requests and clears its mask
// Assumes: accept and release are one-cycle pulses on pclk
// Notes: only accepts while the bench allows it, so masking can be seen
`timescale 1ns/100ps
`default_nettype none
module mis_cpu_model
    import mis_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request side
    input wire logic cpu_irq,
    input wire logic [15:0] cpu_vector,
    // bench controls
    input wire logic allow,
    input wire logic rel_req,
    // answers
    output logic cpu_accept,
    output logic cpu_mask_release,
    output logic [15:0] taken_vec
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_accept <= 1'b0;
            taken_vec <= VEC_NONE;
        end else begin
            // one pulse per request; the block drops cpu_irq a cycle later
            cpu_accept <= cpu_irq && allow && !cpu_accept;
            if (cpu_irq && allow && !cpu_accept) begin
                taken_vec <= cpu_vector;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_mask_release <= 1'b0;
        end else begin
            cpu_mask_release <= rel_req;
        end
    end
endmodule : mis_cpu_model
`default_nettype wire

/* File: mis_irq_top.sv */
// Purpose: pin sensing, event flags and request/vector logic for the cpu
// Assumes: timer, calendar and serial events are one-cycle pulses on pclk
// Notes: all state frozen while ce is low; timer flags have no reset
`timescale 1ns/100ps
`default_nettype none
module mis_irq_top (
    // clock, reset, freeze
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // external pins, asynchronous
    input wire logic main_irq_pin_n,
    input wire logic aux1_ext_pin,
    input wire logic aux2_ext_pin,
    // timer events and low bytes
    input wire logic counter_wrap_evt,
    input wire logic compare_match_evt,
    input wire logic capture_edge_evt,
    input wire logic [7:0] counter_lo_byte,
    input wire logic [7:0] compare_lo_byte,
    input wire logic [7:0] capture_lo_byte,
    // calendar
    input wire logic [4:0] rtc_hours,
    input wire logic [5:0] rtc_minutes,
    input wire logic second_tick,
    // serial peripheral
    input wire logic spi_xfer_done_evt,
    input wire logic spi_collision_evt,
    input wire logic spi_mode_fault_evt,
    input wire logic [7:0] spi_rx_byte,
    // cpu core
    input wire logic cpu_accept,
    input wire logic cpu_mask_release,
    output logic cpu_irq,
    output logic [15:0] cpu_vector,
    output logic cpu_mask
);
    import mis_pkg::*;

    // flag update: a set in the same cycle as a clear wins
    function automatic logic [2:0] flag_next(input logic [2:0] flag, input logic [2:0] set,
                                             input logic [2:0] clr);
        flag_next = (flag & ~clr) | set;
    endfunction : flag_next

    // edge-only or level-and-falling-edge sensing
    function automatic logic sense(input logic edge_only, input logic fall, input logic low);
        sense = fall | (~edge_only & low);
    endfunction : sense

    logic [2:0] pin_s1_reg, pin_s2_reg, pin_d_reg;
    logic [2:0] fall, low;
    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    logic [IDXW-1:0] idx;
    logic hit;
    logic [7:0] rd_byte;
    logic acc_done, rd_done, wr_done;
    logic [2:0] tmr_flag_reg, tmr_arm_reg, tmr_en_reg, tmr_clr;
    logic [1:0] ext_flag_reg, ext_en_reg, ext_set, ext_clr;
    logic [2:0] misc_reg;
    logic main_latch_reg;
    logic [2:0] rtc_flag_reg, rtc_en_reg, rtc_set;
    logic [4:0] hours_prev_reg, alm_hour_reg;
    logic [5:0] alm_min_reg;
    logic alarm_match, day_evt;
    logic [2:0] spi_flag_reg, spi_arm_reg, spi_clr;
    logic spi_en_reg;
    logic main_req, aux1_req, aux2_req, tmr_req, rtc_req, spi_req, any_req;
    logic [15:0] vec_sel;
    logic cpu_irq_reg, cpu_mask_reg;
    logic [15:0] cpu_vector_reg;

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign cpu_irq = cpu_irq_reg;
    assign cpu_vector = cpu_vector_reg;
    assign cpu_mask = cpu_mask_reg;

    // pin synchronisers; bit 0 main, 1 aux1, 2 aux2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_reg <= RST_PINS;
            pin_s2_reg <= RST_PINS;
            pin_d_reg <= RST_PINS;
        end else if (ce) begin
            pin_s1_reg <= {aux2_ext_pin, aux1_ext_pin, main_irq_pin_n};
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg <= pin_s2_reg;
        end
    end
    assign fall = pin_d_reg & ~pin_s2_reg;
    assign low = ~pin_s2_reg;

    // apb decode
    assign idx = paddr[IDXW+1:2];
    assign acc_done = ce & psel & penable & pready_reg;
    assign rd_done = acc_done & ~pwrite & ~pslverr_reg;
    assign wr_done = acc_done & pwrite & ~pslverr_reg;

    always_comb begin
        hit = (paddr[1:0] == 2'h0);
        rd_byte = 8'h00;
        if (idx == IDX_TMR_CTRL) begin
            rd_byte[HI3_LSB +: 3] = tmr_en_reg;
        end else if (idx == IDX_TMR_FLAGS) begin
            rd_byte[HI3_LSB +: 3] = tmr_flag_reg;
        end else if (idx == IDX_CAP_LO) begin
            rd_byte = capture_lo_byte;
        end else if (idx == IDX_CMP_LO) begin
            rd_byte = compare_lo_byte;
        end else if (idx == IDX_CNT_LO) begin
            rd_byte = counter_lo_byte;
        end else if (idx == IDX_RTC_FLAGS) begin
            rd_byte[RTC_LSB +: 3] = rtc_flag_reg;
        end else if (idx == IDX_RTC_CTRL) begin
            rd_byte[RTC_LSB +: 3] = rtc_en_reg;
        end else if (idx == IDX_EXT_CTRL) begin
            rd_byte[EXT_FLAG_LSB +: 2] = ext_en_reg;
        end else if (idx == IDX_EXT_STAT) begin
            rd_byte[EXT_FLAG_LSB +: 2] = ext_flag_reg;
            rd_byte[EXT_LVL_LSB +: 2] = pin_s2_reg[2:1];
        end else if (idx == IDX_MISC) begin
            rd_byte[HI3_LSB +: 3] = misc_reg;
        end else if (idx == IDX_SPI_CTRL) begin
            rd_byte[SPI_EN_BIT] = spi_en_reg;
        end else if (idx == IDX_SPI_STAT) begin
            rd_byte[HI3_LSB +: 3] = spi_flag_reg;
        end else if (idx == IDX_SPI_DATA) begin
            rd_byte = spi_rx_byte;
        end else if (idx == IDX_ALM_HOUR) begin
            rd_byte = {3'h0, alm_hour_reg};
        end else if (idx == IDX_ALM_MIN) begin
            rd_byte = {2'h0, alm_min_reg};
        end else begin
            hit = 1'b0;
        end
    end

    // answer is prepared in the setup cycle so every bus output is a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else if (ce) begin
            pready_reg <= psel & ~penable;
            if (psel && !penable) begin
                pslverr_reg <= ~hit;
                prdata_reg <= {24'h0, rd_byte};
            end
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_en_reg <= RST_EN3;
            rtc_en_reg <= RST_EN3;
            ext_en_reg <= RST_EXT_EN;
            misc_reg <= RST_MISC;
            spi_en_reg <= 1'b0;
            alm_hour_reg <= RST_ALM_HOUR;
            alm_min_reg <= RST_ALM_MIN;
        end else if (wr_done) begin
            if (idx == IDX_TMR_CTRL) begin
                tmr_en_reg <= pwdata[HI3_LSB +: 3];
            end else if (idx == IDX_RTC_CTRL) begin
                rtc_en_reg <= pwdata[RTC_LSB +: 3];
            end else if (idx == IDX_EXT_CTRL) begin
                ext_en_reg <= pwdata[EXT_FLAG_LSB +: 2];
            end else if (idx == IDX_MISC) begin
                misc_reg <= pwdata[HI3_LSB +: 3];
            end else if (idx == IDX_SPI_CTRL) begin
                spi_en_reg <= pwdata[SPI_EN_BIT];
            end else if (idx == IDX_ALM_HOUR) begin
                alm_hour_reg <= pwdata[4:0];
            end else if (idx == IDX_ALM_MIN) begin
                alm_min_reg <= pwdata[5:0];
            end
        end
    end

    // aux pins: flag per selected condition, write one to clear
    assign ext_set[0] = sense(misc_reg[MISC_AUX1_BIT-HI3_LSB], fall[1], low[1]);
    assign ext_set[1] = sense(misc_reg[MISC_AUX2_BIT-HI3_LSB], fall[2], low[2]);
    assign ext_clr = (wr_done && idx == IDX_EXT_STAT) ? pwdata[EXT_FLAG_LSB +: 2] : 2'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_flag_reg <= 2'h0;
        end else if (ce) begin
            ext_flag_reg <= (ext_flag_reg & ~ext_clr) | ext_set;
        end
    end

    // main pin: hidden latch, dropped when its vector is accepted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_latch_reg <= 1'b0;
        end else if (ce) begin
            if (fall[0]) begin
                main_latch_reg <= 1'b1;
            end else if (cpu_accept && cpu_irq_reg && cpu_vector_reg == VEC_MAIN) begin
                main_latch_reg <= 1'b0;
            end
        end
    end
    assign main_req = main_latch_reg | (~misc_reg[MISC_MAIN_BIT-HI3_LSB] & low[0]);

    // timer flags {capture, compare, wrap}; reset leaves them alone
    assign tmr_clr = tmr_arm_reg & {acc_done && !pslverr_reg && idx == IDX_CAP_LO,
                                    acc_done && !pslverr_reg && idx == IDX_CMP_LO,
                                    rd_done && idx == IDX_CNT_LO};
    always_ff @(posedge pclk) begin
        if (ce) begin
            tmr_flag_reg <= flag_next(tmr_flag_reg,
                {capture_edge_evt, compare_match_evt, counter_wrap_evt}, tmr_clr);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_arm_reg <= 3'h0;
        end else if (ce) begin
            if (rd_done && idx == IDX_TMR_FLAGS) begin
                tmr_arm_reg <= tmr_flag_reg;
            end else begin
                tmr_arm_reg <= tmr_arm_reg & ~tmr_clr;
            end
        end
    end

    // calendar flags {second, alarm, day}, write one to clear
    assign day_evt = (hours_prev_reg == HOUR_LAST) && (rtc_hours == HOUR_FIRST);
    assign alarm_match = (rtc_hours == alm_hour_reg) && (rtc_minutes == alm_min_reg);
    assign rtc_set = {second_tick, alarm_match, day_evt};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hours_prev_reg <= HOUR_FIRST;
            rtc_flag_reg <= 3'h0;
        end else if (ce) begin
            hours_prev_reg <= rtc_hours;
            rtc_flag_reg <= flag_next(rtc_flag_reg, rtc_set,
                (wr_done && idx == IDX_RTC_FLAGS) ? pwdata[RTC_LSB +: 3] : 3'h0);
        end
    end

    // serial flags {mode fault, collision, done}
    assign spi_clr = spi_arm_reg & {3{acc_done && !pslverr_reg &&
                     (idx == IDX_SPI_CTRL || idx == IDX_SPI_DATA)}};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spi_flag_reg <= 3'h0;
            spi_arm_reg <= 3'h0;
        end else if (ce) begin
            spi_flag_reg <= flag_next(spi_flag_reg,
                {spi_mode_fault_evt, spi_collision_evt, spi_xfer_done_evt}, spi_clr);
            if (acc_done && !pslverr_reg && idx == IDX_SPI_STAT) begin
                spi_arm_reg <= spi_flag_reg;
            end else begin
                spi_arm_reg <= spi_arm_reg & ~spi_clr;
            end
        end
    end

    // requests and vector priority; aux2 and serial share a vector
    assign aux1_req = ext_flag_reg[0] & ext_en_reg[0];
    assign aux2_req = ext_flag_reg[1] & ext_en_reg[1];
    assign tmr_req = |(tmr_flag_reg & tmr_en_reg);
    assign rtc_req = |(rtc_flag_reg & rtc_en_reg);
    assign spi_req = (|spi_flag_reg) & spi_en_reg;
    assign any_req = main_req | aux1_req | tmr_req | aux2_req | spi_req | rtc_req;

    always_comb begin
        vec_sel = VEC_NONE;
        if (main_req) begin
            vec_sel = VEC_MAIN;
        end else if (aux1_req) begin
            vec_sel = VEC_AUX1;
        end else if (tmr_req) begin
            vec_sel = VEC_TMR;
        end else if (aux2_req || spi_req) begin
            vec_sel = VEC_AUX2_SPI;
        end else if (rtc_req) begin
            vec_sel = VEC_RTC;
        end
    end

    // cpu side: acceptance sets the mask, release comes from the stacked state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_mask_reg <= RST_MASK;
            cpu_irq_reg <= 1'b0;
            cpu_vector_reg <= VEC_NONE;
        end else if (ce) begin
            if (cpu_accept && cpu_irq_reg) begin
                cpu_mask_reg <= 1'b1;
            end else if (cpu_mask_release) begin
                cpu_mask_reg <= 1'b0;
            end
            cpu_irq_reg <= any_req & ~cpu_mask_reg & ~(cpu_accept & cpu_irq_reg);
            cpu_vector_reg <= vec_sel;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_AUX_LEVEL: assert property (ce && rd_done && idx == IDX_EXT_STAT |->
        prdata_reg[1:0] == $past(pin_s2_reg[2:1]))
        else $error("aux level bits do not follow pins");
    AST_AUX_SET_CLR: assert property (ce && ext_set[0] |=> ext_flag_reg[0])
        else $error("aux1 flag lost a set");
    AST_AUX_HOLD: assert property (ce && ext_flag_reg[0] && !ext_clr[0] |=> ext_flag_reg[0])
        else $error("aux1 flag dropped without a clear");
    AST_EDGE_ONLY: assert property (ce && misc_reg[1] && !fall[1] && !ext_flag_reg[0]
        && !(wr_done && idx == IDX_MISC) |=> !ext_flag_reg[0])
        else $error("aux1 flag set without edge in edge mode");
    AST_MAIN_LEVEL: assert property (ce && !misc_reg[0] && low[0] && !cpu_mask_reg
        && !cpu_accept |=> cpu_irq_reg)
        else $error("low main pin not requesting");
    AST_TMR_EN_RST: assert property ($rose(presetn) |-> tmr_en_reg == RST_EN3 && !tmr_req)
        else $error("timer enables not cleared by reset");
    AST_WRAP_CLR: assert property (tmr_clr[0] && !counter_wrap_evt |=> !tmr_flag_reg[0])
        else $error("wrap flag not cleared by sequence");
    AST_DAY: assert property (ce && day_evt ##1 ce && rtc_en_reg[0] && !cpu_mask_reg
        && !cpu_accept |=> cpu_irq_reg)
        else $error("day rollover gave no request");
    AST_ALARM: assert property (ce && alarm_match |=> rtc_flag_reg[1])
        else $error("alarm flag not held during match");
    AST_ACCEPT: assert property (ce && cpu_accept && cpu_irq_reg |=>
        cpu_mask_reg && !cpu_irq_reg)
        else $error("acceptance did not mask");
    AST_SPI_REQ: assert property (ce && spi_req && !main_req && !aux1_req && !tmr_req
        |=> cpu_vector_reg == VEC_AUX2_SPI)
        else $error("serial request wrong vector");
    AST_TMR_VEC: assert property (ce && tmr_req && !main_req && !aux1_req |=>
        cpu_vector_reg == VEC_TMR)
        else $error("timer request wrong vector");
    AST_WRAP_SET: assert property (ce && counter_wrap_evt |=>
        tmr_flag_reg[0])
        else $error("wrap flag not set by event");
    AST_CMP_CLR: assert property (ce && tmr_clr[1] && !compare_match_evt |=>
        !tmr_flag_reg[1])
        else $error("compare flag not cleared by sequence");
    AST_CAP_CLR: assert property (ce && tmr_clr[2] && !capture_edge_evt |=>
        !tmr_flag_reg[2])
        else $error("capture flag not cleared by sequence");
    AST_SECOND: assert property (ce && second_tick |=>
        rtc_flag_reg[2])
        else $error("second tick not flagged");
    AST_AUX1_REQ: assert property (ce && aux1_req && !main_req && !cpu_mask_reg
        && !cpu_accept |=> cpu_irq_reg && cpu_vector_reg == VEC_AUX1)
        else $error("enabled aux1 flag gave no request");
    AST_RTC_VEC: assert property (ce && rtc_req && !main_req && !aux1_req && !tmr_req
        && !aux2_req && !spi_req |=> cpu_vector_reg == VEC_RTC)
        else $error("calendar request wrong vector");
    AST_MASK_BLOCK: assert property (ce && cpu_mask_reg |=>
        !cpu_irq_reg)
        else $error("request passed a set mask");
endmodule : mis_irq_top
`default_nettype wire

/* File: mis_pkg.sv */
// Purpose: constants for the interrupt source block (register indexes, fields, vectors)
// Assumes: APB byte address = 4 * register index; 8-bit registers in bits 7:0
// Notes: Notes on behaviour below
// Notes on behaviour
// - each aux pin has a read-only level bit: one high, zero low
// - aux flag sets on selected condition; software clears it by writing one
// - main pin select bit 5 of 0x27: one edge only, zero level and edge
// - bits 6 and 7 of 0x27 give the same choice for aux pins
// - three timer flags in top bits of 0x13 share one timer request
// - wrap flag sets on counter wrap; cleared by status read then counter-low read
// - compare flag sets on match; cleared by status read then compare-low access
// - capture flag sets on capture edge; cleared by status read then capture-low access
// - reset leaves the three timer flags untouched
// - each timer flag has an enable in 0x12; reset clears them all
// - requests reach the cpu only while mask clear; acceptance sets the mask
// - calendar request when any enabled day, alarm or second flag is set
// - day event when hours roll from twenty-three to zero
// - with second enable set, one interrupt every calendar second
// - alarm event when hour and minute alarms both equal the time
// - calendar request vectors through 0x3ff2/0x3ff3
// - alarm flag re-asserts while both equalities hold; software changes alarm
// - serial request when any status flag set and enable set; shares the aux2 vector 0x3ff4
// - serial flag clears after status access then data or control access
// - aux enables in 0x25 allow or block each aux request; reset zero
package mis_pkg;
    localparam int IDXW = 6;
    // register indexes, byte address is four times these
    localparam logic [IDXW-1:0] IDX_TMR_CTRL = 6'h12;
    localparam logic [IDXW-1:0] IDX_TMR_FLAGS = 6'h13;
    localparam logic [IDXW-1:0] IDX_CAP_LO = 6'h15;
    localparam logic [IDXW-1:0] IDX_CMP_LO = 6'h17;
    localparam logic [IDXW-1:0] IDX_CNT_LO = 6'h19;
    localparam logic [IDXW-1:0] IDX_RTC_FLAGS = 6'h1c;
    localparam logic [IDXW-1:0] IDX_RTC_CTRL = 6'h1d;
    localparam logic [IDXW-1:0] IDX_EXT_CTRL = 6'h25;
    localparam logic [IDXW-1:0] IDX_EXT_STAT = 6'h26;
    localparam logic [IDXW-1:0] IDX_MISC = 6'h27;
    localparam logic [IDXW-1:0] IDX_SPI_CTRL = 6'h2a;
    localparam logic [IDXW-1:0] IDX_SPI_STAT = 6'h2b;
    localparam logic [IDXW-1:0] IDX_SPI_DATA = 6'h2c;
    localparam logic [IDXW-1:0] IDX_ALM_HOUR = 6'h30;
    localparam logic [IDXW-1:0] IDX_ALM_MIN = 6'h31;
    // field positions: three-bit groups sit at bits 7:5 or 2:0
    localparam int HI3_LSB = 5;
    localparam int RTC_LSB = 0;
    localparam int EXT_FLAG_LSB = 6;
    localparam int EXT_LVL_LSB = 0;
    localparam int MISC_MAIN_BIT = 5;
    localparam int MISC_AUX1_BIT = 6;
    localparam int MISC_AUX2_BIT = 7;
    localparam int SPI_EN_BIT = 7;
    // reset values
    localparam logic [2:0] RST_EN3 = 3'h0;
    localparam logic [1:0] RST_EXT_EN = 2'h0;
    localparam logic [2:0] RST_MISC = 3'h0;
    localparam logic [4:0] RST_ALM_HOUR = 5'h00;
    localparam logic [5:0] RST_ALM_MIN = 6'h00;
    localparam logic [2:0] RST_PINS = 3'h7;
    localparam logic RST_MASK = 1'b1;
    // calendar
    localparam logic [4:0] HOUR_LAST = 5'h17;
    localparam logic [4:0] HOUR_FIRST = 5'h00;
    // service vectors
    localparam logic [15:0] VEC_MAIN = 16'h3ffa;
    localparam logic [15:0] VEC_AUX1 = 16'h3ff8;
    localparam logic [15:0] VEC_TMR = 16'h3ff6;
    localparam logic [15:0] VEC_AUX2_SPI = 16'h3ff4;
    localparam logic [15:0] VEC_RTC = 16'h3ff2;
    localparam logic [15:0] VEC_NONE = 16'h0000;
endpackage : mis_pkg

/* File: tb_mcu_interrupt_sources.sv */
// Purpose: self-checking bench for the interrupt source block
// Assumes: zero-wait apb slave, cpu model as far side
// Notes: timer flags are cleared once before their own checks
`timescale 1ns/100ps
`default_nettype none
module tb_mcu_interrupt_sources;
    import mis_pkg::*;
    typedef struct packed {logic w; logic [5:0] a; logic [7:0] wd; logic [7:0] x;} mis_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, main_n, aux1, aux2;
    logic allow, rel_req, cpu_accept, cpu_rel, cpu_irq, cpu_mask, ce;
    logic [7:0] paddr, d;
    logic [31:0] pwdata, prdata;
    logic [6:0] ev;
    logic [4:0] hours;
    logic [5:0] mins;
    logic [15:0] cpu_vector, taken_vec;
    logic e;
    logic [5:0] lo_idx [3] = '{IDX_CNT_LO, IDX_CMP_LO, IDX_CAP_LO};
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    mis_row_t rows [8] = '{'{0, IDX_MISC, 8'h00, 8'h00}, '{0, IDX_EXT_CTRL, 8'h00, 8'h00},
        '{0, IDX_TMR_CTRL, 8'h00, 8'h00}, '{0, IDX_EXT_STAT, 8'h00, 8'h03},
        '{0, IDX_CNT_LO, 8'h00, 8'h3c}, '{1, IDX_MISC, 8'hff, 8'he0},
        '{1, IDX_MISC, 8'h00, 8'h00}, '{1, IDX_RTC_CTRL, 8'hff, 8'h07}};
    mis_irq_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .main_irq_pin_n(main_n),
        .aux1_ext_pin(aux1), .aux2_ext_pin(aux2), .counter_wrap_evt(ev[0]),
        .compare_match_evt(ev[1]), .capture_edge_evt(ev[2]), .counter_lo_byte(8'h3c),
        .compare_lo_byte(8'h5a), .capture_lo_byte(8'h69), .rtc_hours(hours),
        .rtc_minutes(mins), .second_tick(ev[3]), .spi_xfer_done_evt(ev[4]),
        .spi_collision_evt(ev[5]), .spi_mode_fault_evt(ev[6]), .spi_rx_byte(8'h96),
        .cpu_accept(cpu_accept), .cpu_mask_release(cpu_rel), .cpu_irq(cpu_irq),
        .cpu_vector(cpu_vector), .cpu_mask(cpu_mask));
    mis_cpu_model cpu (.pclk(pclk), .presetn(presetn), .cpu_irq(cpu_irq),
        .cpu_vector(cpu_vector), .allow(allow), .rel_req(rel_req), .cpu_accept(cpu_accept),
        .cpu_mask_release(cpu_rel), .taken_vec(taken_vec));
    task automatic wrap_up();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] x);
        n_checks++;
        if (seen !== x) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, x, seen);
        end
    endtask : chk
    // idle edge first, so a back-to-back call never re-drives psel in one step
    task automatic apb(input logic w, input logic [5:0] a, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {a, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // values read right after the edge are the ones that edge sampled
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        d = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [5:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk("rdata", {8'h00, d}, {8'h00, x});
    endtask : rd
    task automatic pulse(input logic [6:0] m);
        @(posedge pclk);
        ev <= m;
        @(posedge pclk);
        ev <= 7'h00;
    endtask : pulse
    task automatic rel();
        @(posedge pclk);
        rel_req <= 1'b1;
        @(posedge pclk);
        rel_req <= 1'b0;
    endtask : rel
    task automatic irq_chk(input logic [15:0] v);
        int k;
        k = 0;
        while (cpu_irq !== 1'b1 && k < 30) begin
            @(negedge pclk);
            k++;
        end
        chk("vector", cpu_vector, v);
        @(posedge pclk);
        allow <= 1'b1;
        repeat (3) @(posedge pclk);
        allow <= 1'b0;
        @(negedge pclk);
        chk("taken", taken_vec, v);
        chk("mask", {cpu_mask, cpu_irq}, 16'h0002);
    endtask : irq_chk
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ev, allow, rel_req} = '0;
        ce = 1'b1;
        {main_n, aux1, aux2, hours, mins} = {3'h7, 5'h05, 6'h10};
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) apb(1'b1, rows[i].a, rows[i].wd);
            rd(rows[i].a, rows[i].x);
        end
        apb(1'b1, IDX_EXT_CTRL, 8'h40);
        aux1 <= 1'b0;
        repeat (6) @(posedge pclk);
        rd(IDX_EXT_STAT, 8'h42);
        chk("masked", {15'h0, cpu_irq}, 16'h0000);
        rel();
        irq_chk(VEC_AUX1);
        apb(1'b1, IDX_EXT_STAT, 8'h40);
        rd(IDX_EXT_STAT, 8'h42);
        apb(1'b1, IDX_MISC, 8'h40);
        apb(1'b1, IDX_EXT_STAT, 8'h40);
        rd(IDX_EXT_STAT, 8'h02);
        aux1 <= 1'b1;
        repeat (6) @(posedge pclk);
        aux1 <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b1, IDX_EXT_CTRL, 8'h00);
        rd(IDX_EXT_STAT, 8'h42);
        apb(1'b1, IDX_EXT_STAT, 8'h40);
        rd(IDX_EXT_STAT, 8'h02);
        pulse(7'h07);
        apb(1'b0, IDX_TMR_FLAGS, 8'h00);
        for (int i = 0; i < 3; i++) apb(1'b0, lo_idx[i], 8'h00);
        for (int i = 0; i < 3; i++) begin
            pulse(7'h01 << i);
            apb(1'b0, lo_idx[i], 8'h00);
            apb(1'b0, IDX_TMR_FLAGS, 8'h00);
            chk("tmr set", {15'h0, d[5+i]}, 16'h0001);
            apb(1'b0, lo_idx[i], 8'h00);
            apb(1'b0, IDX_TMR_FLAGS, 8'h00);
            chk("tmr clr", {15'h0, d[5+i]}, 16'h0000);
        end
        apb(1'b1, IDX_TMR_CTRL, 8'h20);
        pulse(7'h01);
        rel();
        irq_chk(VEC_TMR);
        rd(IDX_TMR_FLAGS, 8'h20);
        rd(IDX_CNT_LO, 8'h3c);
        apb(1'b1, IDX_TMR_CTRL, 8'h00);
        apb(1'b1, IDX_SPI_CTRL, 8'h80);
        pulse(7'h10);
        rel();
        irq_chk(VEC_AUX2_SPI);
        apb(1'b0, IDX_SPI_DATA, 8'h00);
        rd(IDX_SPI_STAT, 8'h20);
        rd(IDX_SPI_DATA, 8'h96);
        rd(IDX_SPI_STAT, 8'h00);
        pulse(7'h60);
        rd(IDX_SPI_STAT, 8'hc0);
        apb(1'b0, IDX_SPI_CTRL, 8'h00);
        rd(IDX_SPI_STAT, 8'h00);
        apb(1'b1, IDX_SPI_CTRL, 8'h00);
        pulse(7'h08);
        rd(IDX_RTC_FLAGS, 8'h04);
        apb(1'b1, IDX_RTC_CTRL, 8'h04);
        rel();
        irq_chk(VEC_RTC);
        apb(1'b1, IDX_RTC_FLAGS, 8'h04);
        apb(1'b1, IDX_RTC_CTRL, 8'h00);
        hours <= HOUR_LAST;
        repeat (3) @(posedge pclk);
        hours <= HOUR_FIRST;
        repeat (3) @(posedge pclk);
        rd(IDX_RTC_FLAGS, 8'h01);
        apb(1'b1, IDX_ALM_MIN, 8'h10);
        rd(IDX_RTC_FLAGS, 8'h03);
        apb(1'b1, IDX_RTC_FLAGS, 8'h03);
        rd(IDX_RTC_FLAGS, 8'h02);
        apb(1'b1, IDX_ALM_MIN, 8'h11);
        apb(1'b1, IDX_RTC_FLAGS, 8'h02);
        rd(IDX_RTC_FLAGS, 8'h00);
        pulse(7'h02);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, IDX_TMR_FLAGS, 8'h00);
        chk("tmr kept", {15'h0, d[6]}, 16'h0001);
        rd(IDX_TMR_CTRL, 8'h00);
        main_n <= 1'b0;
        repeat (6) @(posedge pclk);
        main_n <= 1'b1;
        rel();
        irq_chk(VEC_MAIN);
        rel();
        repeat (8) @(posedge pclk);
        chk("main once", {15'h0, cpu_irq}, 16'h0000);
        ce <= 1'b0;
        pulse(7'h08);
        ce <= 1'b1;
        rd(IDX_RTC_FLAGS, 8'h00);
        apb(1'b0, 6'h3f, 8'h00);
        chk("unmapped", {7'h00, e, d}, 16'h0100);
        aux2 <= 1'b0;
        repeat (6) @(posedge pclk);
        rd(IDX_EXT_STAT, 8'hc0);
        wrap_up();
    end
endmodule : tb_mcu_interrupt_sources
`default_nettype wire
